// >>> dtc_pkg.sv
// Package of constants for the dual timer/counter block
//=====================================================================
// How it works
// - Unit 1 flag: overflow sets, ack/software change
// - Unit 0 flag: overflow sets, ack/software change
// - Run bit low freezes count; high counts
// - Mode 0 counts high byte plus five bits
// - Count needs run and (no gate or pin)
// - Gate select follows gate pin level
// - Mode 0 roll 1FFF to 0 sets flag
// - Mode 1 roll FFFF to 0 sets flag
// - Mode 2 low byte reloads from high byte
// - Only unit 1 overflow drives baud tick
// - Unit 1 in mode 3 is frozen
// - Split low byte uses unit 0 controls
// - Split high byte uses unit 1 run/flag
// - Split: unit 1 ignores run, no flag
// - Split: unit 1 still gives baud ticks
// - Peripheral clock is supplied as pclk
// - Timer ticks every six clocks; select bits
// - Count pin sampled per machine cycle
// - Mode bits: 13, 16, reload, split/halt
package dtc_pkg;

    //=================================================================
    // Register indices; byte address is four times the index
    localparam logic [9:0]  IDX_CONTROL = 10'h088;
    localparam logic [9:0]  IDX_MODE    = 10'h089;
    localparam logic [9:0]  IDX_U0_LOW  = 10'h08A;
    localparam logic [9:0]  IDX_U1_LOW  = 10'h08B;
    localparam logic [9:0]  IDX_U0_HIGH = 10'h08C;
    localparam logic [9:0]  IDX_U1_HIGH = 10'h08D;

    //=================================================================
    // Control register bit positions
    localparam int          CTL_FLAG1 = 7;
    localparam int          CTL_RUN1  = 6;
    localparam int          CTL_FLAG0 = 5;
    localparam int          CTL_RUN0  = 4;

    //=================================================================
    // Mode register bit positions (unit 1 in upper nibble)
    localparam int          MOD_GATE0   = 3;
    localparam int          MOD_CT0     = 2;
    localparam int          MOD_SEL0_LO = 0;
    localparam int          MOD_GATE1   = 7;
    localparam int          MOD_CT1     = 6;
    localparam int          MOD_SEL1_LO = 4;

    //=================================================================
    // Reset values and timing
    localparam logic [7:0]  REG_RESET   = 8'h00;
    localparam int          MC_CLOCKS   = 6;
    localparam logic [2:0]  MC_LAST     = 3'(MC_CLOCKS - 1);

    //=================================================================
    // Operating modes
    typedef enum logic [1:0] {
        MODE_13BIT  = 2'b00,
        MODE_16BIT  = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT  = 2'b11
    } dtc_mode_e;

endpackage : dtc_pkg

// >>> dtc_pin_sampler.sv
// Pin synchroniser and machine-cycle edge sampler for one unit
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_sampler (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Machine cycle strobe
    input  wire logic mc_tick,
    // External pins
    input  wire logic count_pin,
    input  wire logic gate_pin,
    // Sampled results
    output logic      count_fall,
    output logic      gate_level
);
    logic [1:0] cnt_sync_reg;
    logic [1:0] gate_sync_reg;
    logic       cnt_samp_reg;
    logic       fall_reg;

    //=================================================================
    // Two-stage synchronisers; first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_sync_reg  <= 2'h0;
            gate_sync_reg <= 2'h0;
        end else begin
            cnt_sync_reg  <= {cnt_sync_reg[0], count_pin};
            gate_sync_reg <= {gate_sync_reg[0], gate_pin};
        end
    end

    //=================================================================
    // One sample per machine cycle; high then low is a count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_samp_reg <= 1'b0;
            fall_reg     <= 1'b0;
        end else begin
            fall_reg <= mc_tick & cnt_samp_reg & ~cnt_sync_reg[1];
            if (mc_tick) begin
                cnt_samp_reg <= cnt_sync_reg[1];
            end
        end
    end

    // Pulses shorter than a machine cycle may be missed
    assign count_fall = fall_reg;
    assign gate_level = gate_sync_reg[1];

endmodule : dtc_pin_sampler
`default_nettype wire

// >>> dtc_timer_top.sv
// Dual 16-bit timer/counter with four modes and an APB slave
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_top
    import dtc_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // External pins
    input  wire logic        unit0_count_pin,
    input  wire logic        unit1_count_pin,
    input  wire logic        unit0_gate_pin,
    input  wire logic        unit1_gate_pin,
    // Interrupt controller side
    output logic             unit0_irq,
    output logic             unit1_irq,
    input  wire logic        unit0_irq_ack,
    input  wire logic        unit1_irq_ack,
    // Serial port baud source
    output logic             unit1_baud_tick
);

    //=================================================================
    // Step one unit: returns {overflow, high, low}
    function automatic logic [16:0] dtc_step(input logic [1:0] mode,
                                             input logic [7:0] hi,
                                             input logic [7:0] lo);
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0]  s8;
        s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        s16 = {1'b0, hi, lo} + 17'h00001;
        s8  = {1'b0, lo} + 9'h001;
        case (mode)
            MODE_13BIT:  dtc_step = {s13[13], s13[12:5], lo[7:5],
                                     s13[4:0]};
            MODE_16BIT:  dtc_step = s16;
            MODE_RELOAD: dtc_step = {s8[8], hi,
                                     s8[8] ? hi : s8[7:0]};
            default:     dtc_step = {1'b0, hi, lo};
        endcase
    endfunction : dtc_step

    //=================================================================
    // Register state
    logic [7:0] mode_reg;
    logic [7:0] u0_lo_reg;
    logic [7:0] u0_hi_reg;
    logic [7:0] u1_lo_reg;
    logic [7:0] u1_hi_reg;
    logic       flag0_reg;
    logic       flag1_reg;
    logic       run0_reg;
    logic       run1_reg;
    logic [2:0] mc_cnt_reg;
    logic       baud_reg;

    //=================================================================
    // APB decode; zero wait states, unmapped words flag an error
    logic [9:0] idx;
    logic       acc;
    logic       wr;
    logic       hit_ctl;
    logic       hit_mod;
    logic       hit_t0l;
    logic       hit_t0h;
    logic       hit_t1l;
    logic       hit_t1h;
    logic       mapped;
    logic [7:0] rd_byte;
    logic [7:0] wbyte;

    assign idx     = paddr[11:2];
    assign acc     = psel & penable;
    assign wr      = acc & pwrite;
    assign hit_ctl = (idx == IDX_CONTROL);
    assign hit_mod = (idx == IDX_MODE);
    assign hit_t0l = (idx == IDX_U0_LOW);
    assign hit_t0h = (idx == IDX_U0_HIGH);
    assign hit_t1l = (idx == IDX_U1_LOW);
    assign hit_t1h = (idx == IDX_U1_HIGH);
    assign mapped  = hit_ctl | hit_mod | hit_t0l | hit_t0h | hit_t1l
                   | hit_t1h;
    assign wbyte   = pwdata[7:0];
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    // Read mux; external-interrupt bits are not in this block
    assign rd_byte = hit_ctl ? {flag1_reg, run1_reg, flag0_reg, run0_reg,
                                4'h0}
                   : hit_mod ? mode_reg
                   : hit_t0l ? u0_lo_reg
                   : hit_t0h ? u0_hi_reg
                   : hit_t1l ? u1_lo_reg
                   : hit_t1h ? u1_hi_reg
                   : 8'h00;
    assign prdata  = {24'h000000, rd_byte};

    //=================================================================
    // Machine cycle prescaler; pclk is the peripheral clock
    logic mc_tick;
    assign mc_tick = (mc_cnt_reg == MC_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mc_cnt_reg <= 3'h0;
        end else begin
            mc_cnt_reg <= mc_tick ? 3'h0 : mc_cnt_reg + 3'h1;
        end
    end

    //=================================================================
    // Pin sampling for both units
    logic fall0;
    logic fall1;
    logic gpin0;
    logic gpin1;

    dtc_pin_sampler u_pins0 (
        .pclk      (pclk),
        .presetn   (presetn),
        .mc_tick   (mc_tick),
        .count_pin (unit0_count_pin),
        .gate_pin  (unit0_gate_pin),
        .count_fall(fall0),
        .gate_level(gpin0)
    );

    dtc_pin_sampler u_pins1 (
        .pclk      (pclk),
        .presetn   (presetn),
        .mc_tick   (mc_tick),
        .count_pin (unit1_count_pin),
        .gate_pin  (unit1_gate_pin),
        .count_fall(fall1),
        .gate_level(gpin1)
    );

    //=================================================================
    // Mode fields and count enables
    logic [1:0] mode0;
    logic [1:0] mode1;
    logic       split;
    logic       src0;
    logic       src1;
    logic       en0;
    logic       en1;
    logic       tick0;
    logic       tick1;
    logic       tick_hi;

    assign mode0 = mode_reg[MOD_SEL0_LO +: 2];
    assign mode1 = mode_reg[MOD_SEL1_LO +: 2];
    assign split = (mode0 == MODE_SPLIT);
    assign src0  = mode_reg[MOD_CT0] ? fall0 : mc_tick;
    assign src1  = mode_reg[MOD_CT1] ? fall1 : mc_tick;
    assign en0   = run0_reg & (~mode_reg[MOD_GATE0] | gpin0);
    // Split mode takes the run bit away from unit 1, not its gate
    assign en1   = (split | run1_reg)
                 & (~mode_reg[MOD_GATE1] | gpin1);
    assign tick0 = en0 & src0;
    assign tick1 = en1 & src1 & (mode1 != MODE_SPLIT);
    assign tick_hi = split & run1_reg & mc_tick;

    //=================================================================
    // Next counts for both units
    logic [16:0] step0;
    logic [16:0] step1;
    logic [8:0]  lo0_inc;
    logic [8:0]  hi0_inc;
    logic        ovf0;
    logic        ovf1;
    logic        ovf_hi;
    logic [7:0]  u0_lo_cnt;
    logic [7:0]  u0_hi_cnt;

    assign step0   = dtc_step(mode0, u0_hi_reg, u0_lo_reg);
    assign step1   = dtc_step(mode1, u1_hi_reg, u1_lo_reg);
    assign lo0_inc = {1'b0, u0_lo_reg} + 9'h001;
    assign hi0_inc = {1'b0, u0_hi_reg} + 9'h001;
    assign ovf0    = tick0 & (split ? lo0_inc[8] : step0[16]);
    assign ovf1    = tick1 & step1[16];
    assign ovf_hi  = tick_hi & hi0_inc[8];

    // Split mode counts the two bytes of unit 0 separately
    assign u0_lo_cnt = !tick0 ? u0_lo_reg
                     : split  ? lo0_inc[7:0] : step0[7:0];
    assign u0_hi_cnt = split  ? (tick_hi ? hi0_inc[7:0] : u0_hi_reg)
                     : tick0  ? step0[15:8] : u0_hi_reg;

    //=================================================================
    // Flag sources: in split mode unit 0 high byte owns unit 1 flag
    logic set0;
    logic set1;
    assign set0 = ovf0;
    assign set1 = split ? ovf_hi : ovf1;

    //=================================================================
    // Counter bytes; a software write wins over a count step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            u0_lo_reg <= REG_RESET;
            u0_hi_reg <= REG_RESET;
            u1_lo_reg <= REG_RESET;
            u1_hi_reg <= REG_RESET;
        end else begin
            u0_lo_reg <= (wr && hit_t0l) ? wbyte : u0_lo_cnt;
            u0_hi_reg <= (wr && hit_t0h) ? wbyte : u0_hi_cnt;
            u1_lo_reg <= (wr && hit_t1l) ? wbyte
                       : tick1 ? step1[7:0] : u1_lo_reg;
            u1_hi_reg <= (wr && hit_t1h) ? wbyte
                       : tick1 ? step1[15:8] : u1_hi_reg;
        end
    end

    //=================================================================
    // Control and mode registers; overflow beats any clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg  <= REG_RESET;
            run0_reg  <= 1'b0;
            run1_reg  <= 1'b0;
            flag0_reg <= 1'b0;
            flag1_reg <= 1'b0;
        end else begin
            if (wr && hit_mod) begin
                mode_reg <= wbyte;
            end
            if (wr && hit_ctl) begin
                run0_reg <= wbyte[CTL_RUN0];
                run1_reg <= wbyte[CTL_RUN1];
            end
            if (set0) begin
                flag0_reg <= 1'b1;
            end else if (wr && hit_ctl) begin
                flag0_reg <= wbyte[CTL_FLAG0];
            end else if (unit0_irq_ack) begin
                flag0_reg <= 1'b0;
            end
            if (set1) begin
                flag1_reg <= 1'b1;
            end else if (wr && hit_ctl) begin
                flag1_reg <= wbyte[CTL_FLAG1];
            end else if (unit1_irq_ack) begin
                flag1_reg <= 1'b0;
            end
        end
    end

    //=================================================================
    // Baud tick from unit 1 only, kept in split mode too
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_reg <= 1'b0;
        end else begin
            baud_reg <= ovf1;
        end
    end

    assign unit1_baud_tick = baud_reg;
    assign unit0_irq       = flag0_reg;
    assign unit1_irq       = flag1_reg;

    //=================================================================
    // Assertions; a bus write in the same cycle may override a check
    a_flag0_overflow_set: assert property (@(posedge pclk)
        disable iff (!presetn)
        set0 |=> flag0_reg && unit0_irq)
        else $error("unit 0 flag missed an overflow");

    a_flag1_overflow_set: assert property (@(posedge pclk)
        disable iff (!presetn)
        set1 |=> flag1_reg)
        else $error("unit 1 flag missed an overflow");

    a_ack_clears_flag0: assert property (@(posedge pclk)
        disable iff (!presetn)
        unit0_irq_ack && !set0 && !(wr && hit_ctl) |=> !flag0_reg)
        else $error("ack did not clear unit 0 flag");

    a_halted_unit_holds: assert property (@(posedge pclk)
        disable iff (!presetn)
        !run0_reg && !wr |=> $stable(u0_lo_reg))
        else $error("halted unit 0 low byte moved");

    a_mode0_top_bits: assert property (@(posedge pclk)
        disable iff (!presetn)
        mode0 == MODE_13BIT && !wr |=> $stable(u0_lo_reg[7:5]))
        else $error("mode 0 touched upper low-byte bits");

    // Split excluded: there the high byte runs on unit 1 run bit
    a_gate_blocks_count: assert property (@(posedge pclk)
        disable iff (!presetn)
        mode_reg[MOD_GATE0] && !gpin0 && !split && !wr
        |=> $stable({u0_hi_reg, u0_lo_reg}))
        else $error("unit 0 counted with gate low");

    // Split excluded: unit 1 may not touch its flag there
    a_mode2_reload: assert property (@(posedge pclk)
        disable iff (!presetn)
        mode1 == MODE_RELOAD && !split && tick1 && u1_lo_reg == 8'hFF
        && !wr |=> u1_lo_reg == $past(u1_hi_reg) && flag1_reg)
        else $error("mode 2 reload wrong");

    a_unit1_frozen: assert property (@(posedge pclk)
        disable iff (!presetn)
        mode1 == MODE_SPLIT && !wr
        ##0 (mode1 == MODE_SPLIT && !wr) [*3]
        |=> $stable(u1_lo_reg))
        else $error("unit 1 counted in mode 3");

    // Judged from the count itself, not from the overflow wire
    a_baud_from_unit1: assert property (@(posedge pclk)
        disable iff (!presetn)
        mode1 == MODE_16BIT && tick1 && {u1_hi_reg, u1_lo_reg} == 16'hFFFF
        && !wr |=> unit1_baud_tick)
        else $error("unit 1 wrap gave no baud tick");

    a_split_hi_flag: assert property (@(posedge pclk)
        disable iff (!presetn)
        split && ovf1 && !ovf_hi && !(wr && hit_ctl) && !flag1_reg
        |=> !flag1_reg)
        else $error("unit 1 set its flag in split mode");

    a_mc_period: assert property (@(posedge pclk)
        disable iff (!presetn)
        mc_tick |=> !mc_tick [*5] ##1 mc_tick)
        else $error("machine cycle is not six clocks");

    c_mode0_roll: cover property (@(posedge pclk) disable iff (!presetn)
        mode0 == MODE_13BIT && set0);
    c_mode2_reload: cover property (@(posedge pclk) disable iff (!presetn)
        mode1 == MODE_RELOAD && ovf1);
    c_split_hi_roll: cover property (@(posedge pclk) disable iff (!presetn)
        ovf_hi);
    c_pin_count: cover property (@(posedge pclk) disable iff (!presetn)
        mode_reg[MOD_CT0] && tick0);

endmodule : dtc_timer_top
`default_nettype wire

// >>> dtc_pin_model.sv
// Behavioural model of the external count and gate pin drivers
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
    // Clock
    input  wire logic pclk,
    // Pins toward the block
    output var logic  count0,
    output var logic  count1,
    output var logic  gate0,
    output var logic  gate1
);
    //=========================================================
    // Levels held two machine cycles so the sync margin is safe
    localparam int HOLD = 12;

    // Pins idle high on count, low on gate
    initial begin
        count0 = 1'b1;
        count1 = 1'b1;
        gate0  = 1'b0;
        gate1  = 1'b0;
    end

    // Falling pulses on one count pin, each level held HOLD clocks
    task automatic pulses(input int unit, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            count0 <= (unit == 0) ? 1'b0 : count0;
            count1 <= (unit == 1) ? 1'b0 : count1;
            repeat (HOLD) @(posedge pclk);
            count0 <= 1'b1;
            count1 <= 1'b1;
            repeat (HOLD) @(posedge pclk);
        end
    endtask : pulses

    // Gate pin level change, taken right after an edge
    task automatic set_gate(input int unit, input logic lvl);
        @(posedge pclk);
        gate0 <= (unit == 0) ? lvl : gate0;
        gate1 <= (unit == 1) ? lvl : gate1;
    endtask : set_gate
endmodule : dtc_pin_model
`default_nettype wire

// >>> dtc_timer_top_tb.sv
// Self-checking testbench of the dual timer/counter block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dtc_timer_top_tb;
    import dtc_pkg::*;
    //=========================================================
    // Byte addresses of the registers
    localparam logic [11:0] A_CTL = {IDX_CONTROL, 2'b00};
    localparam logic [11:0] A_MOD = {IDX_MODE, 2'b00};
    localparam logic [11:0] A_T0L = {IDX_U0_LOW, 2'b00};
    localparam logic [11:0] A_T1L = {IDX_U1_LOW, 2'b00};
    localparam logic [11:0] A_T0H = {IDX_U0_HIGH, 2'b00};
    localparam logic [11:0] A_T1H = {IDX_U1_HIGH, 2'b00};

    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        last_err;
    logic        cnt0, cnt1, gate0, gate1;
    logic        irq0, irq1, baud;
    logic        ack0    = 1'b0;
    logic        ack1    = 1'b0;
    int          n_errors = 0;
    int          n_checks = 0;
    int          n_baud   = 0;

    always #50 pclk = ~pclk;

    // Baud ticks are single-cycle pulses, so count them at each edge
    always @(posedge pclk) if (baud === 1'b1) n_baud <= n_baud + 1;

    dtc_pin_model pins (.pclk(pclk), .count0(cnt0), .count1(cnt1),
        .gate0(gate0), .gate1(gate1));

    dtc_timer_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .unit0_count_pin(cnt0),
        .unit1_count_pin(cnt1), .unit0_gate_pin(gate0),
        .unit1_gate_pin(gate1), .unit0_irq(irq0), .unit1_irq(irq1),
        .unit0_irq_ack(ack0), .unit1_irq_ack(ack1),
        .unit1_baud_tick(baud));

    //=========================================================
    // Closing report
    task automatic end_sim();
        if (n_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    //=========================================================
    // APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            end_sim();
        end
        q        = prdata[7:0];
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        apb(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [7:0] q);
        apb(1'b0, a, 8'h00, q);
    endtask : rd

    // Bounded wait for an interrupt level; a hang ends the run
    task automatic wait_irq(input int u, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge pclk);
            if ((u == 0 ? irq0 : irq1) === 1'b1) break;
        end
        if (i == lim) begin
            n_errors++;
            end_sim();
        end
    endtask : wait_irq

    // One-cycle acknowledge pulse, then look after it has landed
    task automatic ack(input int u);
        @(posedge pclk);
        ack0 <= (u == 0);
        ack1 <= (u == 1);
        @(posedge pclk);
        ack0 <= 1'b0;
        ack1 <= 1'b0;
        @(negedge pclk);
    endtask : ack

    //=========================================================
    // Scenarios
    task automatic t_reset();
        logic [7:0] q;
        for (int i = 0; i < 6; i++) begin
            rd({IDX_CONTROL + 10'(i), 2'b00}, q);
            `CHK(q, REG_RESET)
        end
        rd(12'h000, q);
        `CHK({last_err, q}, 9'h100)
        `CHK({irq0, irq1, baud}, 3'b000)
    endtask : t_reset

    task automatic t_mode1();
        logic [7:0] q;
        int         b0;
        wr(A_MOD, 8'h01);
        wr(A_T0H, 8'hFF);
        wr(A_T0L, 8'hFF);
        b0 = n_baud;
        wr(A_CTL, 8'h10);
        wait_irq(0, 40);
        wr(A_CTL, 8'h20);
        rd(A_T0L, q);
        `CHK(q, 8'h00)
        rd(A_T0H, q);
        `CHK(q, 8'h00)
        rd(A_CTL, q);
        `CHK(q, 8'h20)
        `CHK(n_baud, b0)
        ack(0);
        `CHK(irq0, 1'b0)
        wr(A_CTL, 8'h20);
        @(negedge pclk);
        `CHK(irq0, 1'b1)
        wr(A_CTL, 8'h00);
        @(negedge pclk);
        `CHK(irq0, 1'b0)
    endtask : t_mode1

    // Upper three low-byte bits must survive the 13-bit wrap
    task automatic t_mode0();
        logic [7:0] q;
        int         b0;
        wr(A_MOD, 8'h00);
        wr(A_T1H, 8'hFF);
        wr(A_T1L, 8'hFF);
        b0 = n_baud;
        wr(A_CTL, 8'h40);
        wait_irq(1, 40);
        wr(A_CTL, 8'h80);
        rd(A_T1L, q);
        `CHK(q, 8'hE0)
        rd(A_T1H, q);
        `CHK(q, 8'h00)
        `CHK(n_baud, b0 + 1)
        ack(1);
        `CHK(irq1, 1'b0)
    endtask : t_mode0

    task automatic t_mode2();
        logic [7:0] q;
        wr(A_MOD, 8'h20);
        wr(A_T1H, 8'hF0);
        wr(A_T1L, 8'hFE);
        wr(A_CTL, 8'h40);
        wait_irq(1, 40);
        wr(A_CTL, 8'h00);
        rd(A_T1L, q);
        `CHK(q, 8'hF0)
        rd(A_T1H, q);
        `CHK(q, 8'hF0)
    endtask : t_mode2

    task automatic t_hold();
        logic [7:0] q1, q2;
        wr(A_MOD, 8'h01);
        wr(A_T0L, 8'h00);
        wr(A_T0H, 8'h00);
        wr(A_CTL, 8'h10);
        repeat (30) @(posedge pclk);
        wr(A_CTL, 8'h00);
        rd(A_T0L, q1);
        repeat (30) @(posedge pclk);
        rd(A_T0L, q2);
        `CHK(q2, q1)
        `CHK(q1 != 8'h00, 1'b1)
    endtask : t_hold

    // Sixty clocks of gate high is ten machine ticks; the check accepts eight to eleven
    task automatic t_gate();
        logic [7:0] q;
        wr(A_MOD, 8'h09);
        wr(A_T0L, 8'h00);
        wr(A_T0H, 8'h00);
        wr(A_CTL, 8'h10);
        repeat (60) @(posedge pclk);
        rd(A_T0L, q);
        `CHK(q, 8'h00)
        pins.set_gate(0, 1'b1);
        repeat (60) @(posedge pclk);
        pins.set_gate(0, 1'b0);
        repeat (12) @(posedge pclk);
        wr(A_CTL, 8'h00);
        rd(A_T0L, q);
        `CHK(q >= 8'd8 && q <= 8'd11, 1'b1)
    endtask : t_gate

    task automatic t_counter();
        logic [7:0] q;
        wr(A_MOD, 8'h05);
        wr(A_T0L, 8'h00);
        wr(A_T0H, 8'h00);
        wr(A_CTL, 8'h10);
        pins.pulses(0, 3);
        repeat (24) @(posedge pclk);
        wr(A_CTL, 8'h00);
        rd(A_T0L, q);
        `CHK(q, 8'h03)
    endtask : t_counter

    task automatic t_split();
        logic [7:0] q, q2;
        int         b0;
        wr(A_MOD, 8'h13);
        wr(A_T0L, 8'h00);
        wr(A_T0H, 8'hFF);
        wr(A_T1L, 8'h00);
        wr(A_T1H, 8'h00);
        wr(A_CTL, 8'h40);
        wait_irq(1, 40);
        rd(A_CTL, q);
        `CHK(q, 8'hC0)
        rd(A_T0L, q);
        `CHK(q, 8'h00)
        wr(A_CTL, 8'h00);
        wr(A_T1H, 8'hFF);
        wr(A_T1L, 8'hFF);
        b0 = n_baud;
        repeat (60) @(posedge pclk);
        `CHK(irq1, 1'b0)
        `CHK(n_baud > b0, 1'b1)
        wr(A_MOD, 8'h33);
        rd(A_T1L, q);
        repeat (30) @(posedge pclk);
        rd(A_T1L, q2);
        `CHK(q2, q)
    endtask : t_split

    //=========================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_mode1();
        t_mode0();
        t_mode2();
        t_hold();
        t_gate();
        t_counter();
        t_split();
        end_sim();
    end
endmodule : dtc_timer_top_tb
`default_nettype wire
